// File: logic/adcsq_ctrl.sv
// result fifo with valid/ready on both sides
module adcsq_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16,
  parameter int PTR_BITS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic full,
  output logic empty,
  output logic [PTR_BITS-1:0] head,
  output logic [PTR_BITS-1:0] tail
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_BITS-1:0] head;
    logic [PTR_BITS-1:0] tail;
    logic [PTR_BITS:0] count;
  } adcsq_fifo_state_type;

  adcsq_fifo_state_type st;
  adcsq_fifo_state_type next_st;
  logic push;
  logic pop;

  // honest flags from the occupancy count
  assign full = (st.count == (PTR_BITS+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign empty = (st.count == '0);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = st.mem[st.tail];
  assign head = st.head;
  assign tail = st.tail;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointer and storage update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.head] = in_data;
      next_st.head = (st.head == PTR_BITS'(DEPTH - 1)) ? '0 : st.head + 1'b1;
    end
    if (pop) begin
      next_st.tail = (st.tail == PTR_BITS'(DEPTH - 1)) ? '0 : st.tail + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end
endmodule : adcsq_fifo

// sample sequencer with apb register slave
module adcsq_ctrl #(
  parameter int NUM_SLOTS = 8,
  parameter bit SINGLE_SLOT = 1'b0,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic conv_req,
  output logic [3:0] conv_input,
  output logic conv_temp,
  output logic conv_diff,
  input wire logic conv_done,
  input wire logic [9:0] conv_data,
  output logic raw_interrupt_flag,
  output logic seq_irq
);
  localparam int SLOTS = SINGLE_SLOT ? 1 : NUM_SLOTS;

  typedef struct packed {
    logic [31:0] ctl;
    logic [31:0] mux;
    logic interrupt_mask_bit;
    logic raw;
    logic ovf;
    logic unf;
    adcsq_pkg::adcsq_seq_type seq;
    logic [2:0] slot;
    logic [31:0] rdata;
  } adcsq_top_state_type;

  adcsq_top_state_type st;
  adcsq_top_state_type next_st;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [9:0] fifo_out_data;
  logic fifo_full;
  logic fifo_empty;
  logic [3:0] fifo_head;
  logic [3:0] fifo_tail;
  logic fifo_push;
  logic fifo_pop;
  logic setup;
  logic access_wr;
  logic mapped;
  logic [3:0] nib;
  logic [3:0] pin_sel;
  logic slot_last;
  logic [31:0] ctl_view;

  // control nibble and input nibble of the current slot
  assign nib = st.ctl[st.slot*adcsq_pkg::SLOT_BITS +: adcsq_pkg::SLOT_BITS];
  assign pin_sel = st.mux[st.slot*adcsq_pkg::SLOT_BITS +: adcsq_pkg::SLOT_BITS];
  assign ctl_view = SINGLE_SLOT ? (st.ctl | (32'h1 << adcsq_pkg::FLD_LAST)) : st.ctl;
  assign slot_last = ctl_view[st.slot*adcsq_pkg::SLOT_BITS + adcsq_pkg::FLD_LAST]
                     | (st.slot == 3'(SLOTS - 1));

  // converter request, stalled while the fifo has no room
  assign conv_req = (st.seq == adcsq_pkg::SEQ_REQ) & fifo_in_ready;
  assign conv_temp = nib[adcsq_pkg::FLD_TEMP];
  assign conv_input = pin_sel;
  assign conv_diff = nib[adcsq_pkg::FLD_DIFF] & ~nib[adcsq_pkg::FLD_TEMP];
  assign fifo_push = (st.seq == adcsq_pkg::SEQ_WAIT) & conv_done;

  // apb phases and decode
  assign setup = psel & ~penable;
  assign access_wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign prdata = st.rdata;
  assign fifo_pop = setup & ~pwrite & (paddr == adcsq_pkg::ADDR_RESULT_FIFO);
  assign pslverr = psel & penable & ~mapped;
  assign seq_irq = st.raw & st.interrupt_mask_bit;
  assign raw_interrupt_flag = st.raw;

  // address decode
  always_comb begin
    if (paddr == adcsq_pkg::ADDR_RAW_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == adcsq_pkg::ADDR_IRQ_MASK) begin
      mapped = 1'b1;
    end else if (paddr == adcsq_pkg::ADDR_OVERFLOW) begin
      mapped = 1'b1;
    end else if (paddr == adcsq_pkg::ADDR_UNDERFLOW) begin
      mapped = 1'b1;
    end else if (paddr == adcsq_pkg::ADDR_START) begin
      mapped = 1'b1;
    end else if (paddr == adcsq_pkg::ADDR_INPUT_SELECT) begin
      mapped = 1'b1;
    end else if (paddr == adcsq_pkg::ADDR_SAMPLE_CONTROL) begin
      mapped = 1'b1;
    end else if (paddr == adcsq_pkg::ADDR_RESULT_FIFO) begin
      mapped = 1'b1;
    end else if (paddr == adcsq_pkg::ADDR_FIFO_STATUS) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // next state: registers, read data, sequencer
  always_comb begin
    next_st = st;
    // read data captured in the setup cycle
    if (setup && !pwrite) begin
      next_st.rdata = adcsq_pkg::RST_REG;
      if (paddr == adcsq_pkg::ADDR_RAW_STATUS) begin
        next_st.rdata[0] = st.raw;
      end else if (paddr == adcsq_pkg::ADDR_IRQ_MASK) begin
        next_st.rdata[0] = st.interrupt_mask_bit;
      end else if (paddr == adcsq_pkg::ADDR_OVERFLOW) begin
        next_st.rdata[0] = st.ovf;
      end else if (paddr == adcsq_pkg::ADDR_UNDERFLOW) begin
        next_st.rdata[0] = st.unf;
      end else if (paddr == adcsq_pkg::ADDR_START) begin
        next_st.rdata[0] = (st.seq != adcsq_pkg::SEQ_IDLE);
      end else if (paddr == adcsq_pkg::ADDR_INPUT_SELECT) begin
        next_st.rdata = st.mux;
      end else if (paddr == adcsq_pkg::ADDR_SAMPLE_CONTROL) begin
        next_st.rdata = ctl_view;
      end else if (paddr == adcsq_pkg::ADDR_RESULT_FIFO) begin
        if (fifo_out_valid) begin
          next_st.rdata[adcsq_pkg::RESULT_BITS-1:0] = fifo_out_data;
        end
      end else if (paddr == adcsq_pkg::ADDR_FIFO_STATUS) begin
        next_st.rdata[adcsq_pkg::STAT_FULL] = fifo_full;
        next_st.rdata[adcsq_pkg::STAT_EMPTY] = fifo_empty;
        next_st.rdata[adcsq_pkg::STAT_HEAD +: 4] = fifo_head;
        next_st.rdata[adcsq_pkg::STAT_TAIL +: 4] = fifo_tail;
      end
    end
    // writes take effect in the access cycle; flags clear on write one
    if (access_wr) begin
      if (paddr == adcsq_pkg::ADDR_RAW_STATUS) begin
        next_st.raw = st.raw & ~pwdata[0];
      end else if (paddr == adcsq_pkg::ADDR_IRQ_MASK) begin
        next_st.interrupt_mask_bit = pwdata[0];
      end else if (paddr == adcsq_pkg::ADDR_OVERFLOW) begin
        next_st.ovf = st.ovf & ~pwdata[0];
      end else if (paddr == adcsq_pkg::ADDR_UNDERFLOW) begin
        next_st.unf = st.unf & ~pwdata[0];
      end else if (paddr == adcsq_pkg::ADDR_INPUT_SELECT) begin
        next_st.mux = pwdata;
      end else if (paddr == adcsq_pkg::ADDR_SAMPLE_CONTROL) begin
        next_st.ctl = pwdata;
      end else if (paddr == adcsq_pkg::ADDR_START) begin
        if (pwdata[0] && st.seq == adcsq_pkg::SEQ_IDLE) begin
          next_st.seq = adcsq_pkg::SEQ_REQ;
          next_st.slot = '0;
        end
      end
    end
    if (fifo_pop && !fifo_out_valid) begin
      next_st.unf = 1'b1;
    end
    // sequencer
    case (st.seq)
      adcsq_pkg::SEQ_IDLE: begin
      end
      adcsq_pkg::SEQ_REQ: begin
        if (fifo_in_ready) begin
          next_st.seq = adcsq_pkg::SEQ_WAIT;
        end else begin
          next_st.ovf = 1'b1;
        end
      end
      adcsq_pkg::SEQ_WAIT: begin
        if (conv_done) begin
          if (nib[adcsq_pkg::FLD_IRQ]) begin
            next_st.raw = 1'b1;
          end
          if (slot_last) begin
            next_st.seq = adcsq_pkg::SEQ_IDLE;
          end else begin
            next_st.slot = st.slot + 3'd1;
            next_st.seq = adcsq_pkg::SEQ_REQ;
          end
        end
      end
      default: begin
        next_st.seq = adcsq_pkg::SEQ_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // result fifo
  adcsq_fifo #(
    .WIDTH(adcsq_pkg::RESULT_BITS),
    .DEPTH(FIFO_DEPTH),
    .PTR_BITS(4)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(conv_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .full(fifo_full),
    .empty(fifo_empty),
    .head(fifo_head),
    .tail(fifo_tail)
  );
endmodule : adcsq_ctrl

// File: logic/adcsq_pkg.sv
package adcsq_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_RAW_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h008;
  localparam logic [11:0] ADDR_OVERFLOW = 12'h010;
  localparam logic [11:0] ADDR_UNDERFLOW = 12'h014;
  localparam logic [11:0] ADDR_START = 12'h028;
  localparam logic [11:0] ADDR_INPUT_SELECT = 12'h040;
  localparam logic [11:0] ADDR_SAMPLE_CONTROL = 12'h044;
  localparam logic [11:0] ADDR_RESULT_FIFO = 12'h048;
  localparam logic [11:0] ADDR_FIFO_STATUS = 12'h04C;
  // per-slot control nibble field positions
  localparam int SLOT_BITS = 4;
  localparam int FLD_DIFF = 0;
  localparam int FLD_LAST = 1;
  localparam int FLD_IRQ = 2;
  localparam int FLD_TEMP = 3;
  // fifo status field positions
  localparam int STAT_FULL = 12;
  localparam int STAT_EMPTY = 8;
  localparam int STAT_HEAD = 4;
  localparam int STAT_TAIL = 0;
  localparam int RESULT_BITS = 10;
  // reset values
  localparam logic [31:0] RST_REG = 32'h0000_0000;
  localparam logic [31:0] RST_FIFO_STATUS = 32'h0000_0100;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_REQ, SEQ_WAIT} adcsq_seq_type;
endpackage : adcsq_pkg

// File: sim/adcsq_checker.sv
module adcsq_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic conv_req,
  input wire logic [3:0] conv_input,
  input wire logic conv_temp,
  input wire logic conv_diff,
  input wire logic conv_done,
  input wire logic raw_interrupt_flag,
  input wire logic seq_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // one clock domain for all checks
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  temp_no_diff_a: assert property (conv_temp |-> !conv_diff)
    else $error("differential with sensor");
  irq_needs_raw_a: assert property (seq_irq |-> raw_interrupt_flag)
    else $error("irq without raw flag");
  raw_from_done_a: assert property ($rose(raw_interrupt_flag) |-> $past(conv_done))
    else $error("raw flag without completion");
  raw_sticky_a: assert property (raw_interrupt_flag
    && !(psel && penable && pwrite) |=> raw_interrupt_flag)
    else $error("raw flag lost");
  req_one_cycle_a: assert property (conv_req && ce |=> !conv_req)
    else $error("request longer than one cycle");
  slot_hold_a: assert property (conv_req
    |=> $stable(conv_input) && $stable(conv_temp) && $stable(conv_diff))
    else $error("slot select changed early");
  result_upper_a: assert property (psel && penable && !pwrite
    && paddr == adcsq_pkg::ADDR_RESULT_FIFO |-> prdata[31:10] == 22'h0)
    else $error("result upper bits set");
  bad_addr_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  bad_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : adcsq_checker

// File: sim/adcsq_ctrl_bench.sv
module adcsq_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, conv_done = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, ctl, mux;
  logic [9:0] conv_data = 10'h000;
  logic pready, pslverr, conv_req, conv_temp, conv_diff, raw_interrupt_flag, seq_irq, err;
  logic irq_exp, ce = 1'b1;
  logic [3:0] conv_input;
  logic [9:0] q[$];
  int fails = 0, n_checks = 0, e, n_push = 0;
  always #25 pclk = ~pclk;
  adcsq_ctrl i_adcsq_ctrl (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_req(conv_req), .conv_input(conv_input),
    .conv_temp(conv_temp), .conv_diff(conv_diff), .conv_done(conv_done),
    .conv_data(conv_data), .raw_interrupt_flag(raw_interrupt_flag), .seq_irq(seq_irq));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // one apb transfer, idle edge first
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) begin
      fails++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // answer n conversions, slots first to first+n-1
  task automatic serve(input int n, input int first = 0);
    int k;
    for (int s = first; s < first + n; s++) begin
      k = 0;
      do begin
        @(negedge pclk);
        k++;
      end while (conv_req !== 1'b1 && k < 40);
      if (k == 40) begin
        fails++;
        finish_test();
      end
      check(conv_temp, ctl[4*s+3]);
      check(conv_diff, ctl[4*s] & ~ctl[4*s+3]);
      check(conv_input, mux[4*s+:4]);
      irq_exp = irq_exp | ctl[4*s+2];
      @(posedge pclk);
      repeat ($urandom_range(2)) @(posedge pclk);
      conv_done <= 1'b1;
      conv_data <= 10'($urandom);
      @(posedge pclk);
      q.push_back(conv_data);
      n_push++;
      conv_done <= 1'b0;
    end
  endtask : serve
  // read back every queued result, then one read too many
  task automatic drain;
    while (q.size() > 0) begin
      apb(1'b0, 12'h048, 32'h0);
      check(rd, {22'h0, q.pop_front()});
    end
    apb(1'b0, 12'h048, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, 12'h014, 32'h1);
  endtask : drain
  initial begin
    void'($urandom(15222));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h04C, 32'h0);
    check(rd, 32'h100);
    apb(1'b0, 12'h044, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    // clock enable low: a write must not land
    ce <= 1'b0;
    apb(1'b1, 12'h008, 32'h1);
    ce <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
    for (int r = 0; r < 5; r++) begin
      e = (r == 0) ? 0 : (r == 1) ? 7 : $urandom_range(7);
      ctl = $urandom;
      mux = $urandom;
      for (int j = 0; j < 8; j++) ctl[4*j+1] = (j == e);
      ctl[4*e+1] = 1'b1;
      irq_exp = 1'b0;
      apb(1'b1, 12'h040, mux);
      apb(1'b1, 12'h044, ctl);
      apb(1'b1, 12'h008, {31'h0, r[0]});
      apb(1'b0, 12'h044, 32'h0);
      check(rd, ctl);
      apb(1'b1, 12'h028, 32'h1);
      serve(e + 1);
      repeat (4) begin
        @(negedge pclk);
        check(conv_req, 1'b0);
      end
      check(raw_interrupt_flag, irq_exp);
      check(seq_irq, irq_exp & r[0]);
      drain();
      apb(1'b1, 12'h004, 32'h1);
      $display("test sequence %0d done", r);
    end
    ctl = 32'h2000_0000;
    apb(1'b1, 12'h044, ctl);
    repeat (2) begin
      apb(1'b1, 12'h028, 32'h1);
      serve(8);
    end
    apb(1'b1, 12'h028, 32'h1);
    repeat (8) begin
      @(negedge pclk);
      check(conv_req, 1'b0);
    end
    apb(1'b0, 12'h04C, 32'h0);
    check(rd, {19'h0, 1'b1, 4'h0, 4'(n_push), 4'(n_push)});
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h1);
    // each read frees one entry; the stalled slot resumes at once
    for (int s = 0; s < 8; s++) begin
      fork
        apb(1'b0, 12'h048, 32'h0);
        serve(1, s);
      join
      check(rd, {22'h0, q.pop_front()});
    end
    drain();
    $display("test overflow done");
    finish_test();
  end
endmodule : adcsq_ctrl_bench
bind adcsq_ctrl adcsq_checker i_adcsq_checker (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pslverr(pslverr), .conv_req(conv_req), .conv_input(conv_input), .conv_temp(conv_temp),
  .conv_diff(conv_diff), .conv_done(conv_done), .raw_interrupt_flag(raw_interrupt_flag),
  .seq_irq(seq_irq));
